// ---- logic/pic_cfg.svh ----
/*
  constants of the interrupt controller: latch indices, vectors, counts.
  assumes inclusion by bare name from the controller files.
*/
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

`define PIC_NSRC        6'd39
`define PIC_IDX_W       6
`define PIC_VEC_W       20
`define PIC_IDX_NONE    6'h00
`define PIC_IDX_SWI     6'h01
`define PIC_IDX_WDT     6'h02
`define PIC_IDX_EXT0    6'h03
`define PIC_IDX_FIRST   6'h03
`define PIC_IDX_LAST    6'h26
`define PIC_VEC_RESET   20'hFFFFC
`define PIC_VEC_SWI     20'hFFFF8
`define PIC_VEC_WDT     20'hFFFF4
`define PIC_VEC_EXT0    20'hFFFF0
`define PIC_VEC_LOW_HI  20'hFFF80
`define PIC_VEC_SER     20'hFFF3C
`define PIC_IDX_SER     6'h20
`define PIC_VEC_STEP    20'h00004
`define PIC_RSV_MASK    39'h00_0000_4090

`endif

// ---- logic/pic_pkg.sv ----
/*
  types shared by the interrupt controller.
  assumes pic_cfg.svh is compiled with it.
*/
package pic_pkg;
  typedef enum logic [1:0] {
    PIC_IDLE,
    PIC_GRANT,
    PIC_SERVICE
  } pic_state_t;
endpackage

// ---- logic/pic_vec_map.sv ----
/*
  vector address map: latch index to vector address.
  assumes index range 0 to 38 from the arbiter.
*/
`timescale 1ns/1ps
`include "pic_cfg.svh"

module pic_vec_map (
  input  wire logic [5:0]  idx_i,
  output logic      [19:0] vec_o
);

  // ------------------------------------------------------------
  // vector decode
  // ------------------------------------------------------------
  function automatic logic [19:0] vec_of(input logic [5:0] k);
    logic [19:0] kk;
    kk = {14'h0000, k};
    if (k == `PIC_IDX_NONE)
      vec_of = `PIC_VEC_RESET;
    else if (k < `PIC_IDX_SER)
      vec_of = `PIC_VEC_RESET - `PIC_VEC_STEP * kk;
    else
      vec_of = `PIC_VEC_SER - `PIC_VEC_STEP * (kk - 20'h00020);
  endfunction

  assign vec_o = vec_of(idx_i);
endmodule

// ---- logic/pic_ctrl.sv ----
/*
  prioritized interrupt controller: pending latches, enables, arbiter,
  grant handshake to the cpu core.
  assumes all inputs synchronous to clock_i; the core acknowledges a
  grant with a one-cycle ack and signals return instructions.
*/
`timescale 1ns/1ps
`include "pic_cfg.svh"

// Functional notes
// - thirty-five sources besides reset, fixed map
// - trap and watchdog ignore enable flags
// - nesting allowed once master enable restored
// - own vector per source, latches except trap
// - request sets pending latch to one
// - maskable needs master and own enable
// - simultaneous requests accepted in hardware order
// - no ranking among non-maskable sources
// - watchdog priority two, latch two, FFFF4
// - ext0 also needs pin enable bit
// - ext1 latch five, ext5 latch fifteen
// - index k uses latch, enable, priority k
// - channel error requests latches eight, nine
// - channel overload requests latches ten, eleven
// - position, waveform, angle latches sixteen-twentyone
// - external two to four latches 29-31
// - serial requests latches thirty-two to 34
// - converter done lowest, latch thirty-eight
// - accepted source latch cleared at once
// - master enable saved then cleared on accept
// - software clears latches, never sets them
// - reset clears master, enables and latches
module pic_ctrl (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        soft_trap_irq_i,
  input  wire logic [38:2] src_irq_i,
  input  wire logic        ext0_pin_enable_i,
  input  wire logic        ei_i,
  input  wire logic        di_i,
  input  wire logic        maskable_return_instr_i,
  input  wire logic        nonmask_return_instr_i,
  input  wire logic        ef_wr_i,
  input  wire logic [38:3] ef_wdata_i,
  input  wire logic        il_clr_i,
  input  wire logic [38:2] il_clr_mask_i,
  input  wire logic        ack_i,
  output logic             irq_req_o,
  output logic      [5:0]  irq_idx_o,
  output logic      [19:0] irq_vec_o,
  output logic             saved_imf_o,
  output logic             master_irq_enable_o,
  output logic      [38:3] source_irq_enable_o,
  output logic      [38:2] pending_latch_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic                master_irq_enable_ff;
  logic                nxt_master_irq_enable;
  logic [38:3]         source_irq_enable_ff;
  logic [38:3]         nxt_source_irq_enable;
  logic [38:2]         pending_latch_ff;
  logic [38:2]         nxt_pending_latch;
  logic                trap_pend_ff;
  logic                nxt_trap_pend;
  logic                saved_imf_ff;
  logic                nxt_saved_imf;
  logic                nmi_active_ff;
  logic                nxt_nmi_active;
  logic                req_ff;
  logic [5:0]          idx_ff;
  logic [19:0]         vec_ff;
  pic_pkg::pic_state_t state_ff;
  pic_pkg::pic_state_t nxt_state;

  // ------------------------------------------------------------
  // qualification and arbitration
  // ------------------------------------------------------------
  logic [38:3] mask_ok;
  logic [38:2] hw_set;
  logic [5:0]  mask_idx;
  logic        mask_any;
  logic        grab;
  logic        nmi_any;
  logic [5:0]  win_idx;
  logic        win_any;
  logic [19:0] win_vec;
  logic        accept;
  logic [38:2] acc_clr;
  logic        acc_mask;

  // ------------------------------------------------------------
  // ranking
  // ------------------------------------------------------------
  function automatic logic [5:0] first_set(input logic [38:3] v);
    logic [5:0] r;
    r = `PIC_IDX_NONE;
    for (int i = 38; i >= 3; i--)
      if (v[i])
        r = 6'(i);
    first_set = r;
  endfunction

  // ------------------------------------------------------------
  // source requests onto latch positions
  // ------------------------------------------------------------
  assign hw_set[2]     = src_irq_i[2];
  assign hw_set[3]     = src_irq_i[3];
  assign hw_set[4]     = 1'b0;
  assign hw_set[5]     = src_irq_i[5];
  assign hw_set[6]     = src_irq_i[6];
  assign hw_set[7]     = 1'b0;
  assign hw_set[9:8]   = src_irq_i[9:8];
  assign hw_set[11:10] = src_irq_i[11:10];
  assign hw_set[13:12] = src_irq_i[13:12];
  assign hw_set[14]    = 1'b0;
  assign hw_set[15]    = src_irq_i[15];
  assign hw_set[21:16] = src_irq_i[21:16];
  assign hw_set[28:22] = src_irq_i[28:22];
  assign hw_set[31:29] = src_irq_i[31:29];
  assign hw_set[34:32] = src_irq_i[34:32];
  assign hw_set[37:35] = src_irq_i[37:35];
  assign hw_set[38]    = src_irq_i[38];

  // ------------------------------------------------------------
  // masking and winner
  // ------------------------------------------------------------
  assign mask_ok[38:4] = pending_latch_ff[38:4] & source_irq_enable_ff[38:4];
  assign mask_ok[3]    = pending_latch_ff[3] & source_irq_enable_ff[3] & ext0_pin_enable_i;
  // trap and watchdog not ranked against each other: trap index first only by encoding
  assign nmi_any  = trap_pend_ff | pending_latch_ff[`PIC_IDX_WDT];
  assign mask_idx = first_set(mask_ok);
  assign mask_any = master_irq_enable_ff & (|mask_ok);
  assign win_any  = nmi_any | mask_any;
  assign win_idx  = trap_pend_ff ? `PIC_IDX_SWI :
                    pending_latch_ff[`PIC_IDX_WDT] ? `PIC_IDX_WDT :
                    mask_idx;
  assign grab     = (state_ff == pic_pkg::PIC_IDLE) & win_any;
  assign accept   = (state_ff == pic_pkg::PIC_GRANT) & ack_i;
  assign acc_mask = idx_ff >= `PIC_IDX_FIRST;

  // ------------------------------------------------------------
  // vector lookup
  // ------------------------------------------------------------
  pic_vec_map u_vec (
    .idx_i (win_idx),
    .vec_o (win_vec)
  );

  // ------------------------------------------------------------
  // acceptance clear
  // ------------------------------------------------------------
  function automatic logic [38:2] clear_one(input logic [5:0] k);
    logic [38:2] m;
    m = '0;
    for (int i = 2; i <= 38; i++)
      if (k == 6'(i))
        m[i] = 1'b1;
    clear_one = m;
  endfunction

  assign acc_clr = accept ? clear_one(idx_ff) : '0;

  // ------------------------------------------------------------
  // next values: pending latches
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_pending_latch = pending_latch_ff & ~acc_clr;
    if (il_clr_i)
      nxt_pending_latch = nxt_pending_latch & ~il_clr_mask_i;
    // set applied last so it wins over any clear
    nxt_pending_latch = nxt_pending_latch | hw_set;
  end

  // ------------------------------------------------------------
  // next values: software trap
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_trap_pend = trap_pend_ff & ~(accept & (idx_ff == `PIC_IDX_SWI));
    nxt_trap_pend = nxt_trap_pend | soft_trap_irq_i;
  end

  // ------------------------------------------------------------
  // next values: enables and stacked master enable
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_source_irq_enable = ef_wr_i ? ef_wdata_i : source_irq_enable_ff;
  end

  always_comb
  begin
    nxt_master_irq_enable = master_irq_enable_ff;
    nxt_saved_imf = saved_imf_ff;
    nxt_nmi_active = nmi_active_ff;
    if (ei_i)
      nxt_master_irq_enable = 1'b1;
    // di wins over ei
    if (di_i)
      nxt_master_irq_enable = 1'b0;
    if (maskable_return_instr_i)
      nxt_master_irq_enable = 1'b1;
    // non-maskable return only acts inside a trap or watchdog routine
    if (nonmask_return_instr_i && nmi_active_ff)
    begin
      nxt_master_irq_enable = saved_imf_ff | master_irq_enable_ff;
      nxt_nmi_active = 1'b0;
    end
    // accept overrides enables and returns
    if (accept)
    begin
      nxt_saved_imf = master_irq_enable_ff;
      nxt_master_irq_enable = 1'b0;
      nxt_nmi_active = ~acc_mask;
    end
  end

  // ------------------------------------------------------------
  // grant state
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      pic_pkg::PIC_IDLE:
        if (win_any)
          nxt_state = pic_pkg::PIC_GRANT;
      pic_pkg::PIC_GRANT:
        if (ack_i)
          nxt_state = pic_pkg::PIC_SERVICE;
      pic_pkg::PIC_SERVICE:
        nxt_state = pic_pkg::PIC_IDLE;
      default:
        nxt_state = pic_pkg::PIC_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      master_irq_enable_ff <= 1'b0;
    else
      master_irq_enable_ff <= nxt_master_irq_enable;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      source_irq_enable_ff <= '0;
    else
      source_irq_enable_ff <= nxt_source_irq_enable;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      pending_latch_ff <= '0;
    else
      pending_latch_ff <= nxt_pending_latch;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      trap_pend_ff <= 1'b0;
    else
      trap_pend_ff <= nxt_trap_pend;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      saved_imf_ff <= 1'b0;
    else
      saved_imf_ff <= nxt_saved_imf;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      nmi_active_ff <= 1'b0;
    else
      nmi_active_ff <= nxt_nmi_active;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      state_ff <= pic_pkg::PIC_IDLE;
    else
      state_ff <= nxt_state;
  end

  // ------------------------------------------------------------
  // grant to the core
  // ------------------------------------------------------------
  // grant held steady while waiting for ack
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      req_ff <= 1'b0;
    else if (grab)
      req_ff <= 1'b1;
    else if (accept)
      req_ff <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      idx_ff <= `PIC_IDX_NONE;
    else if (grab)
      idx_ff <= win_idx;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      vec_ff <= `PIC_VEC_RESET;
    else if (grab)
      vec_ff <= win_vec;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign irq_req_o           = req_ff;
  assign irq_idx_o           = idx_ff;
  assign irq_vec_o           = vec_ff;
  assign saved_imf_o         = saved_imf_ff;
  assign master_irq_enable_o = master_irq_enable_ff;
  assign source_irq_enable_o = source_irq_enable_ff;
  assign pending_latch_o     = pending_latch_ff;
endmodule

// ---- tb/pic_ctrl_chk.sv ----
/*
  port checker of the interrupt controller.
  assumes a bind onto pic_ctrl.
*/
`timescale 1ns/1ps
module pic_ctrl_chk (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic [38:2] src_irq_i,
  input wire logic        ext0_pin_enable_i,
  input wire logic        ack_i,
  input wire logic        irq_req_o,
  input wire logic [5:0]  irq_idx_o,
  input wire logic [19:0] irq_vec_o,
  input wire logic        saved_imf_o,
  input wire logic        master_irq_enable_o,
  input wire logic [38:3] source_irq_enable_o,
  input wire logic [38:2] pending_latch_o
);
  logic [38:3] en_m;
  logic [38:3] sel_m;
  assign en_m = pending_latch_o[38:3] & source_irq_enable_o & {35'h7FFFFFFFF, ext0_pin_enable_i};
  assign sel_m = 36'h1 << (irq_idx_o - 6'd3);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  function automatic logic [19:0] vexp(input logic [5:0] k);
    vexp = (k < 6'd32) ? 20'hFFFFC - {12'h0, k, 2'b0} : 20'hFFFBC - {12'h0, k, 2'b0};
  endfunction
  vec_map_a: assert property (
    irq_req_o |-> irq_vec_o == vexp(irq_idx_o)) else $error("vector off");
  reset_val_a: assert property (
    $past(rst_i) |-> !master_irq_enable_o && source_irq_enable_o == 36'h0
    && pending_latch_o == 37'h0 && !irq_req_o) else $error("reset state off");
  latch_set_a: assert property (
    !$past(rst_i) |-> (pending_latch_o & $past(src_irq_i & ~37'h1024))
    == $past(src_irq_i & ~37'h1024)) else $error("latch not set");
  sw_no_set_a: assert property (
    !$past(rst_i) |-> (pending_latch_o & ~$past(pending_latch_o) & ~$past(src_irq_i))
    == 37'h0) else $error("latch set without request");
  accept_a: assert property (
    irq_req_o && ack_i |=> !irq_req_o && !master_irq_enable_o
    && saved_imf_o == $past(master_irq_enable_o)) else $error("accept off");
  hold_a: assert property (
    irq_req_o && !ack_i |=> irq_req_o && $stable(irq_idx_o)) else $error("grant moved");
  win_a: assert property (
    $rose(irq_req_o) |-> irq_idx_o <= 6'd2 || $past(master_irq_enable_o)
    && !$past(pending_latch_o[2]) && ($past(en_m) & (sel_m - 36'h1)) == 36'h0
    && ($past(en_m) & sel_m) != 36'h0) else $error("wrong winner");
  nmi_go_a: assert property (
    pending_latch_o[2] && !irq_req_o |-> ##[1:4] irq_req_o) else $error("watchdog stuck");
endmodule

// ---- tb/pic_core_model.sv ----
/*
  cpu core model: acks a grant dly_i + 1 cycles after it rises.
  assumes the one-cycle ack handshake.
*/
`timescale 1ns/1ps
module pic_core_model (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       irq_req_i,
  input  wire logic [3:0] dly_i,
  output logic            ack_o
);
  logic [3:0] wait_ff;
  always_ff @(posedge clock_i)
  begin
    wait_ff <= (rst_i || !irq_req_i || ack_o) ? 4'h0 : wait_ff + 4'h1;
    ack_o   <= !rst_i && irq_req_i && !ack_o && wait_ff == dly_i;
  end
endmodule

// ---- tb/pic_ctrl_tb.sv ----
/*
  self-checking bench of the interrupt controller.
  assumes pic_ctrl, pic_core_model, pic_ctrl_chk.
*/
`timescale 1ns/1ps
module pic_ctrl_tb;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        trap = 1'b0;
  logic [38:2] src = '0;
  logic        pin_en = 1'b1;
  logic        ei = 1'b0;
  logic        di = 1'b0;
  logic        mret = 1'b0;
  logic        nret = 1'b0;
  logic [38:2] clr_m = '1;
  logic        ef_wr = 1'b0;
  logic        clr = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic        ack, req, master_irq_enable, sav;
  logic [5:0]  idx;
  logic [19:0] vec;
  logic [38:3] en_o;
  logic [38:2] pl;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  int          k, j;
  always #50 clock_i = ~clock_i;
  pic_ctrl dut_u (.clock_i(clock_i), .rst_i(rst_i), .soft_trap_irq_i(trap), .src_irq_i(src),
    .ext0_pin_enable_i(pin_en), .ei_i(ei), .di_i(di), .maskable_return_instr_i(mret),
    .nonmask_return_instr_i(nret), .ef_wr_i(ef_wr), .ef_wdata_i(36'hFFFFFFFFF),
    .il_clr_i(clr), .il_clr_mask_i(clr_m), .ack_i(ack), .irq_req_o(req),
    .irq_idx_o(idx), .irq_vec_o(vec), .saved_imf_o(sav), .master_irq_enable_o(master_irq_enable),
    .source_irq_enable_o(en_o), .pending_latch_o(pl));
  pic_core_model core_u (.clock_i(clock_i), .rst_i(rst_i), .irq_req_i(req), .dly_i(dly),
    .ack_o(ack));
  task automatic tick();
    @(posedge clock_i);
    #10;
  endtask
  task automatic strobe(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic [19:0] vexp(input int k);
    vexp = (k < 32) ? 20'hFFFFC - 20'(4 * k) : 20'hFFFBC - 20'(4 * k);
  endfunction
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic pulse(input logic [38:2] m);
    src = m;
    tick();
    src = '0;
  endtask
  task automatic grant(input int k, input logic s, input logic nm = 1'b0);
    int t;
    for (t = 0; t < 30 && req !== 1'b1; t++)
      tick();
    chk(idx, k);
    chk(vec, vexp(k));
    for (t = 0; t < 30 && req !== 1'b0; t++)
      tick();
    chk({(k > 1) && pl[k], master_irq_enable, sav}, {2'b00, s});
    if (nm)
      strobe(nret);
    else
      strobe(mret);
  endtask
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  initial
  begin
    k = $urandom(49);
    repeat (20) tick();
    rst_i = 1'b0;
    tick();
    chk({vec, master_irq_enable, en_o, pl, req}, {20'hFFFFC, 75'h0});
    pulse(37'h1026);
    repeat (4) tick();
    chk({req, pl}, 38'h2);
    clr_m = 37'({$urandom(), $urandom()});
    strobe(clr);
    tick();
    chk(pl, 37'h2 & ~clr_m);
    strobe(ef_wr);
    pin_en = 1'b0;
    strobe(ei);
    pulse(37'h2);
    repeat (4) tick();
    chk({req, pl}, 38'h2);
    pin_en = 1'b1;
    grant(3, 1'b1);
    for (k = 5; k <= 38; k++)
      if (!(k inside {7, 14}))
      begin
        dly = 4'($urandom_range(5, 0));
        j = $urandom_range(38, k);
        pulse((37'h1 << (k - 2)) | (37'h1 << (j - 2)));
        grant(k, 1'b1);
        if (j != k && !(j inside {7, 14}))
          grant(j, 1'b1);
      end
    strobe(di);
    pulse(37'h1);
    grant(2, 1'b0);
    strobe(di);
    strobe(trap);
    grant(1, 1'b0);
    strobe(trap);
    grant(1, 1'b1, 1'b1);
    chk(master_irq_enable, 1'b1);
    conclude();
  end
endmodule
bind pic_ctrl pic_ctrl_chk chk_u (.clock_i(clock_i), .rst_i(rst_i), .src_irq_i(src_irq_i),
  .ext0_pin_enable_i(ext0_pin_enable_i), .ack_i(ack_i), .irq_req_o(irq_req_o),
  .irq_idx_o(irq_idx_o), .irq_vec_o(irq_vec_o), .saved_imf_o(saved_imf_o),
  .master_irq_enable_o(master_irq_enable_o), .source_irq_enable_o(source_irq_enable_o),
  .pending_latch_o(pending_latch_o));
